// ---- hw/mte_enable_ctrl.sv ----
// Transmit and receive path enable control of the MAC with register port
//
// Summary of operation
// - Tx enable set: send buffered frames
// - Tx enable clear: no new frame sent
// - Rx enable set: accept frames from PHY
// - Rx enable clear: accept no new frames
// - Run cleared while rx enabled: keeps running
`timescale 1ns/1ps
`include "mte_params.svh"
module mte_enable_ctrl (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Register port
  input  wire mte_pkg::mte_addr_t reg_addr,
  input  wire mte_pkg::mte_word_t reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output mte_pkg::mte_word_t    reg_rdata,
  // Transmit buffer side
  input  wire logic             txb_valid,
  input  wire logic             txb_last,
  input  wire logic [7:0]       txb_data,
  // Cable side
  output logic                  line_valid,
  output logic                  line_last,
  output logic [7:0]            line_data,
  // Internal PHY side
  input  wire logic             phy_valid,
  input  wire logic             phy_last,
  input  wire logic [7:0]       phy_data,
  // Receive DMA side
  output logic                  rxd_valid,
  output logic                  rxd_last,
  output logic [7:0]            rxd_data,
  output logic                  rx_dma_active,
  // Interrupt
  output logic                  irq
);
  import mte_pkg::*;

  logic [1:0] rst_sync_r;
  logic       rst_n;

  // Staged release, so no register leaves reset on a raw edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  logic          tx_path_enable_r;
  logic          tx_path_enable_nxt;
  logic          rx_path_enable_r;
  logic          rx_path_enable_nxt;
  logic          rx_dma_run_r;
  logic          rx_dma_run_nxt;
  mte_rx_state_t rx_process_state_r;
  mte_rx_state_t rx_process_state_nxt;
  logic          rx_process_stopped_flag;
  logic [1:0]    int_stat_r;
  logic [1:0]    int_stat_nxt;
  logic [1:0]    int_mask_r;
  logic [1:0]    int_mask_nxt;
  mte_word_t     reg_rdata_nxt;
  logic          tx_done;
  logic          rx_stop_evt;

  // Reset images of the control words
  localparam logic [3:0] mac_ctrl_rst = `MTE_RST_MAC_CTRL;
  localparam logic [1:0] dma_ctrl_rst = `MTE_RST_DMA_CTRL;

  // Register writes
  always_comb begin
    tx_path_enable_nxt = tx_path_enable_r;
    rx_path_enable_nxt = rx_path_enable_r;
    rx_dma_run_nxt     = rx_dma_run_r;
    int_mask_nxt       = int_mask_r;
    if (reg_wr) begin
      case (reg_addr)
        // Reserved bits 1 and 0 have no storage, so writes there are lost
        `MTE_OFS_MAC_CTRL: begin
          tx_path_enable_nxt = reg_wdata[`MTE_BIT_TX_EN];
          rx_path_enable_nxt = reg_wdata[`MTE_BIT_RX_EN];
        end
        `MTE_OFS_DMA_CTRL: rx_dma_run_nxt = reg_wdata[`MTE_BIT_RX_RUN];
        `MTE_OFS_INT_MASK: int_mask_nxt = reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  // Rx DMA process: stops only once run is clear and receiver already disabled
  always_comb begin
    rx_process_state_nxt = rx_process_state_r;
    case (rx_process_state_r)
      MTE_RX_STOPPED: begin
        if (rx_dma_run_r) begin
          rx_process_state_nxt = MTE_RX_RUNNING;
        end
      end
      MTE_RX_RUNNING: begin
        if (!rx_dma_run_r) begin
          // Receiver still on: the engine cannot stop safely, so it keeps going
          if (rx_path_enable_r) begin
            rx_process_state_nxt = MTE_RX_RUNNING;
          end else begin
            rx_process_state_nxt = MTE_RX_DRAIN;
          end
        end
      end
      // One drain cycle before stopping; a new run request cancels it
      MTE_RX_DRAIN: begin
        if (rx_dma_run_r) begin
          rx_process_state_nxt = MTE_RX_RUNNING;
        end else begin
          rx_process_state_nxt = MTE_RX_STOPPED;
        end
      end
      default: rx_process_state_nxt = MTE_RX_STOPPED;
    endcase
  end

  assign rx_process_stopped_flag = (rx_process_state_r == MTE_RX_STOPPED);
  assign rx_stop_evt = (rx_process_state_r == MTE_RX_DRAIN) && !rx_dma_run_r;
  assign rx_dma_active = !rx_process_stopped_flag;

  // Sticky status; a new event wins over the read that clears it
  always_comb begin
    int_stat_nxt = int_stat_r;
    if (reg_rd && reg_addr == `MTE_OFS_INT_STAT) begin
      int_stat_nxt = 2'b00;
    end
    if (rx_stop_evt) begin
      int_stat_nxt[`MTE_INT_RX_STOP] = 1'b1;
    end
    if (tx_done) begin
      int_stat_nxt[`MTE_INT_TX_DONE] = 1'b1;
    end
  end

  // Read mux; reserved bits read as zero
  always_comb begin
    reg_rdata_nxt = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        `MTE_OFS_MAC_CTRL: begin
          reg_rdata_nxt[`MTE_BIT_TX_EN] = tx_path_enable_r;
          reg_rdata_nxt[`MTE_BIT_RX_EN] = rx_path_enable_r;
        end
        `MTE_OFS_DMA_CTRL: reg_rdata_nxt[`MTE_BIT_RX_RUN] = rx_dma_run_r;
        `MTE_OFS_DMA_STAT: begin
          reg_rdata_nxt[`MTE_BIT_RX_RUN]     = rx_dma_active;
          reg_rdata_nxt[`MTE_BIT_RX_STOPPED] = rx_process_stopped_flag;
        end
        `MTE_OFS_INT_STAT: reg_rdata_nxt[1:0] = int_stat_r;
        `MTE_OFS_INT_MASK: reg_rdata_nxt[1:0] = int_mask_r;
        default: reg_rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_path_enable_r   <= mac_ctrl_rst[`MTE_BIT_TX_EN];
      rx_path_enable_r   <= mac_ctrl_rst[`MTE_BIT_RX_EN];
      rx_dma_run_r       <= dma_ctrl_rst[`MTE_BIT_RX_RUN];
      rx_process_state_r <= MTE_RX_STOPPED;
      int_stat_r         <= 2'b00;
      int_mask_r         <= `MTE_RST_MASK;
      reg_rdata          <= 32'h0000_0000;
    end else begin
      tx_path_enable_r   <= tx_path_enable_nxt;
      rx_path_enable_r   <= rx_path_enable_nxt;
      rx_dma_run_r       <= rx_dma_run_nxt;
      rx_process_state_r <= rx_process_state_nxt;
      int_stat_r         <= int_stat_nxt;
      int_mask_r         <= int_mask_nxt;
      reg_rdata          <= reg_rdata_nxt;
    end
  end

  // Level output; it drops when a status read clears the cause or its mask bit is cleared
  assign irq = |(int_stat_r & int_mask_r);

  // Transmit path: buffer to cable only for frames begun while enabled
  mte_path_gate u_tx_gate (
    .clk        (clk),
    .rst_n      (rst_n),
    .enable     (tx_path_enable_r),
    .in_valid   (txb_valid),
    .in_last    (txb_last),
    .in_data    (txb_data),
    .out_valid  (line_valid),
    .out_last   (line_last),
    .out_data   (line_data),
    .frame_done (tx_done)
  );

  // Receive path: PHY to DMA only for frames begun while enabled
  // Rx frame ends raise no event of their own
  mte_path_gate u_rx_gate (
    .clk        (clk),
    .rst_n      (rst_n),
    .enable     (rx_path_enable_r),
    .in_valid   (phy_valid),
    .in_last    (phy_last),
    .in_data    (phy_data),
    .out_valid  (rxd_valid),
    .out_last   (rxd_last),
    .out_data   (rxd_data),
    .frame_done ()
  );
endmodule : mte_enable_ctrl

// ---- hw/mte_params.svh ----
// Offsets, field positions and reset values for the enable control
`ifndef MTE_PARAMS_SVH
`define MTE_PARAMS_SVH
`define MTE_OFS_MAC_CTRL      8'h00
`define MTE_OFS_DMA_CTRL      8'h04
`define MTE_OFS_DMA_STAT      8'h08
`define MTE_OFS_INT_STAT      8'h0C
`define MTE_OFS_INT_MASK      8'h10
`define MTE_BIT_TX_EN         3
`define MTE_BIT_RX_EN         2
`define MTE_BIT_RX_RUN        1
`define MTE_BIT_RX_STOPPED    0
`define MTE_RST_MAC_CTRL      4'h0
`define MTE_RST_DMA_CTRL      2'h0
`define MTE_RST_MASK          2'h0
`define MTE_INT_RX_STOP       0
`define MTE_INT_TX_DONE       1
`endif

// ---- hw/mte_pkg.sv ----
// Types shared by the enable control files
package mte_pkg;
  typedef enum logic [1:0] {
    MTE_RX_STOPPED = 2'b00,
    MTE_RX_RUNNING = 2'b01,
    MTE_RX_DRAIN   = 2'b10
  } mte_rx_state_t;
  typedef logic [7:0] mte_addr_t;
  typedef logic [31:0] mte_word_t;
endpackage : mte_pkg

// ---- hw/mte_path_gate.sv ----
// Frame-boundary gate for one data path (tx or rx)
`timescale 1ns/1ps
module mte_path_gate (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic enable,
  // Incoming stream
  input  wire logic in_valid,
  input  wire logic in_last,
  input  wire logic [7:0] in_data,
  // Outgoing stream
  output logic       out_valid,
  output logic       out_last,
  output logic [7:0] out_data,
  output logic       frame_done
);
  logic in_frame_r;
  logic in_frame_nxt;
  logic pass_r;
  logic pass_nxt;
  logic out_valid_nxt;
  logic out_last_nxt;
  logic [7:0] out_data_nxt;
  logic done_nxt;

  // Enable only changes admission at a frame start so no frame is cut short
  always_comb begin
    in_frame_nxt  = in_frame_r;
    pass_nxt      = pass_r;
    if (in_valid) begin
      if (!in_frame_r) begin
        pass_nxt = enable;
      end
      in_frame_nxt = !in_last;
    end
    out_valid_nxt = in_valid && (in_frame_r ? pass_r : enable);
    out_last_nxt  = in_valid && in_last && (in_frame_r ? pass_r : enable);
    out_data_nxt  = in_data;
    done_nxt      = out_last_nxt;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_frame_r <= 1'b0;
      pass_r     <= 1'b0;
      out_valid  <= 1'b0;
      out_last   <= 1'b0;
      out_data   <= 8'h00;
      frame_done <= 1'b0;
    end else begin
      in_frame_r <= in_frame_nxt;
      pass_r     <= pass_nxt;
      out_valid  <= out_valid_nxt;
      out_last   <= out_last_nxt;
      out_data   <= out_data_nxt;
      frame_done <= done_nxt;
    end
  end
endmodule : mte_path_gate

// ---- testbench/mte_enable_ctrl_chk.sv ----
// Port assertions for the enable control
`timescale 1ns/1ps
`include "mte_params.svh"
module mte_enable_ctrl_chk (
  // Clock, reset, register port
  input wire logic               clk, rst_b, reg_wr, reg_rd,
  input wire mte_pkg::mte_addr_t reg_addr,
  input wire mte_pkg::mte_word_t reg_wdata, reg_rdata,
  // Streams
  input wire logic               txb_valid, txb_last, line_valid, line_last,
  input wire logic               phy_valid, phy_last, rxd_valid, rxd_last,
  input wire logic [7:0]         txb_data, line_data, phy_data, rxd_data,
  // Status
  input wire logic               rx_dma_active, irq
);
  logic [1:0] en_r;
  // Mirror of the two enable bits as last written
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) en_r <= 2'h0;
    else if (reg_wr && reg_addr == `MTE_OFS_MAC_CTRL) en_r <= reg_wdata[3:2];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_tx_byte: assert property (line_valid |-> $past(txb_valid) && line_data == $past(txb_data))
    else $error("tx byte mismatch");
  a_tx_end: assert property (line_last |-> line_valid && $past(txb_last))
    else $error("tx last mismatch");
  a_rx_byte: assert property (rxd_valid |-> $past(phy_valid) && rxd_data == $past(phy_data))
    else $error("rx byte mismatch");
  a_rx_end: assert property (rxd_last |-> rxd_valid && $past(phy_last))
    else $error("rx last mismatch");
  a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside slot");
  a_rsvd_zero: assert property ($past(reg_rd) && $past(reg_addr) == `MTE_OFS_MAC_CTRL |->
    {reg_rdata[31:4], reg_rdata[1:0]} == 30'h0) else $error("reserved bits set");
  a_en_back: assert property ($past(reg_rd) && $past(reg_addr) == `MTE_OFS_MAC_CTRL |->
    reg_rdata[3:2] == $past(en_r)) else $error("enable readback wrong");
  a_run_start: assert property (reg_wr && reg_addr == `MTE_OFS_DMA_CTRL && reg_wdata[1] |-> ##[1:3] rx_dma_active)
    else $error("rx process not started");
  cover property (line_last);
  cover property (rxd_last);
  cover property (irq);
endmodule : mte_enable_ctrl_chk

// ---- testbench/mte_phy_model.sv ----
// Internal PHY byte source
`timescale 1ns/1ps
module mte_phy_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [3:0] len,
  output logic            valid = 1'b0,
  output logic            last = 1'b0,
  output logic [7:0]      data = 8'h0
);
  logic [3:0] n = 4'h0;
  // Data toggles between frames so a stale byte never looks valid
  always @(posedge clk) begin
    valid <= n != 4'h0;
    last  <= n == 4'h1;
    data  <= (n != 4'h0) ? 8'($urandom) : ~data;
    n     <= (n != 4'h0) ? n - 4'h1 : (go ? len : 4'h0);
  end
endmodule : mte_phy_model

// ---- testbench/mte_enable_ctrl_bench.sv ----
// Self-checking bench for the enable control
`timescale 1ns/1ps
`include "mte_params.svh"
module mte_enable_ctrl_bench;
  import mte_pkg::*;
  localparam mte_addr_t AC = `MTE_OFS_MAC_CTRL, AD = `MTE_OFS_DMA_CTRL, AS = `MTE_OFS_DMA_STAT;
  localparam mte_addr_t AI = `MTE_OFS_INT_STAT, AM = `MTE_OFS_INT_MASK;
  logic       clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, txb_valid = 0, txb_last = 0, go = 0;
  mte_addr_t  reg_addr = 8'h0;
  mte_word_t  reg_wdata = 32'h0;
  logic [7:0] txb_data = 8'h0;
  logic [3:0] len4 = 4'h0;
  wire logic  phy_valid, phy_last, line_valid, line_last, rxd_valid, rxd_last, rx_dma_active, irq;
  wire logic [7:0] phy_data, line_data, rxd_data;
  mte_word_t  reg_rdata;
  int         num_errors = 0, comparisons = 0, len, en;
  // Four-state counters, so an unknown byte strobe cannot vanish into a zero
  integer     tx_n = 0, rx_n = 0;
  mte_phy_model u_phy (.clk(clk), .go(go), .len(len4), .valid(phy_valid), .last(phy_last), .data(phy_data));
  mte_enable_ctrl u_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .txb_valid(txb_valid), .txb_last(txb_last), .txb_data(txb_data),
    .line_valid(line_valid), .line_last(line_last), .line_data(line_data), .phy_valid(phy_valid),
    .phy_last(phy_last), .phy_data(phy_data), .rxd_valid(rxd_valid), .rxd_last(rxd_last), .rxd_data(rxd_data),
    .rx_dma_active(rx_dma_active), .irq(irq));
  initial forever #25 clk = ~clk;
  // Counted mid-cycle, clear of the edge that launches each byte
  always @(negedge clk) begin
    tx_n += line_valid;
    rx_n += rxd_valid;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Expected control word: only the two enable bits survive
  function automatic mte_word_t exp_mac(input logic tx, input logic rx);
    mte_word_t w;
    w = 32'h0000_0000;
    w[`MTE_BIT_TX_EN] = tx;
    w[`MTE_BIT_RX_EN] = rx;
    return w;
  endfunction : exp_mac
  // Bytes that reach the far side of a gated path
  function automatic int exp_bytes(input logic en_bit, input int n);
    return en_bit ? n : 0;
  endfunction : exp_bytes
  task wr(input mte_addr_t a, input mte_word_t d);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) reg_wr <= 1'b0;
  endtask : wr
  task rd(input mte_addr_t a, input mte_word_t e);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  task txf(input int n);
    tx_n = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk) {txb_valid, txb_last, txb_data} <= {1'b1, i == n - 1, 8'($urandom)};
    end
    @(posedge clk) {txb_valid, txb_last} <= 2'h0;
    repeat (3) @(posedge clk);
  endtask : txf
  task rxf(input int n);
    rx_n = 0;
    @(posedge clk) {go, len4} <= {1'b1, 4'(n)};
    @(posedge clk) go <= 1'b0;
    repeat (n + 3) @(posedge clk);
  endtask : rxf
  // Bounded wait on the rx process level
  task wact(input logic e);
    int k;
    for (k = 0; k < 10 && rx_dma_active !== e; k++) @(negedge clk);
    chk(rx_dma_active, e);
    if (k == 10) stop_test();
  endtask : wact
  task stop_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  initial begin
    void'($urandom(19));
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd(AC, exp_mac(1'b0, 1'b0));
    rd(8'hFC, 32'h0000_0000);
    wr(AM, 32'h0000_0002);
    for (int i = 0; i < 6; i++) begin
      en = (i < 2) ? i : $urandom % 2;
      len = 1 + $urandom % 8;
      wr(AC, exp_mac(en[0], 1'b0) | 32'h0000_0003);
      rd(AC, exp_mac(en[0], 1'b0));
      txf(len);
      chk(tx_n, exp_bytes(en[0], len));
      chk(irq, en);
      if (en) rd(AI, 32'h0000_0002);
      chk(irq, 0);
    end
    wr(AM, 32'h0000_0001);
    wr(AC, 32'h0000_0000);
    rxf(4);
    chk(rx_n, exp_bytes(1'b0, 4));
    wr(AD, 32'h0000_0002);
    wact(1'b1);
    wr(AC, exp_mac(1'b0, 1'b1));
    rxf(8);
    chk(rx_n, exp_bytes(1'b1, 8));
    rd(AC, exp_mac(1'b0, 1'b1));
    wr(AD, 32'h0000_0000);
    repeat (4) @(negedge clk);
    chk(rx_dma_active, 1);
    rd(AS, 32'h0000_0002);
    wr(AC, 32'h0000_0000);
    wact(1'b0);
    chk(irq, 1);
    rd(AI, 32'h1);
    chk(irq, 0);
    stop_test();
  end
endmodule : mte_enable_ctrl_bench
bind mte_enable_ctrl mte_enable_ctrl_chk u_chk (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .txb_valid(txb_valid), .txb_last(txb_last),
  .line_valid(line_valid), .line_last(line_last), .phy_valid(phy_valid), .phy_last(phy_last),
  .rxd_valid(rxd_valid), .rxd_last(rxd_last), .txb_data(txb_data), .line_data(line_data), .phy_data(phy_data),
  .rxd_data(rxd_data), .rx_dma_active(rx_dma_active), .irq(irq));
